/* hdl/cba_pkg.sv */
package cba_pkg;

  // ==========================================================================
  // widths
  localparam int ADDR_W = 12;
  localparam int PAGE_W = 4;
  localparam int DATA_W = 8;

  // ==========================================================================
  // status byte positions on the data bus during the address strobe
  localparam int ST_PAGE_LSB  = 0;
  localparam int ST_INPUT_BIT = 4;
  localparam int ST_FETCH_BIT = 5;
  localparam int ST_DELAY_BIT = 6;
  localparam int ST_HALT_BIT  = 7;

  // ==========================================================================
  // timing: a 1 us nominal strobe (1 MHz crystal) at the 40 MHz system clock
  localparam int SYS_CLK_MHZ      = 40;
  localparam int STROBE_TIME_NS   = 1000;
  localparam int ADS_TIME_NS      = 500;
  localparam int STROBE_CYC       = (STROBE_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int ADS_CYC          = (ADS_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int CNT_W            = 8;
  localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] ADS_CNT    = CNT_W'(ADS_CYC - 1);

  // ==========================================================================
  // request from the processor core side
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [PAGE_W-1:0] page;
    logic              isRead;
    logic              isFetch;
    logic              isDelay;
    logic              isHalt;
    logic [DATA_W-1:0] wdata;
  } cba_req_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_ADS,
    ST_DATA,
    ST_DONE
  } cba_state_type;

endpackage : cba_pkg

/* hdl/cba_bus_access.sv */
`timescale 1ns/1ps
// How it works
// - raise bus request before any transfer; wait for chain enable grant
// - with request and grant high, hold bus until done, then drop request
// - hold chain enable out low while owning the bus
// - raise chain enable out when finished to pass control downstream
// - simultaneous requests can both be granted: chain enable out drops in the same cycle that bus request rises
// - drive the latched 12-bit address for the whole cycle
// - during address strobe, data bus carries page bits and four flags
// - input-cycle flag high for read, low for write
// - fetch flag high when fetching an instruction's first byte
// - address strobe first, then exactly one data strobe
// - read data sampled while read strobe low; write data valid while low
// - never assert read and write strobes in the same cycle
// - fast memories are served by the normal strobe length
// - strobe stretched for as long as cycle extend is low
module cba_bus_access
  import cba_pkg::*;
(
  input  wire logic              sys_clk,            // 40 MHz system clock
  input  wire logic              rst_n,              // async reset, active low
  input  wire cba_req_type       coreReq,            // cycle description
  input  wire logic              coreReqValid,       // core asks for a cycle
  output logic                   coreReqReady,       // idle with no cycle requested
  output logic                   coreDone,           // one-cycle completion pulse
  output logic [DATA_W-1:0]      coreRdata,          // data read
  input  wire logic              chainEnableIn,      // grant from upstream
  output logic                   busRequestLine,     // bus request, active high
  output logic                   chainEnableOut,     // grant to downstream
  output logic [ADDR_W-1:0]      lowAddressLines,    // address pin drive
  output logic                   lowAddressOe_n,     // address enable, low drives
  input  wire logic [DATA_W-1:0] dataBusIn,          // data bus pins in
  output logic [DATA_W-1:0]      dataBusOut,         // data bus pins out
  output logic                   dataBusOe_n,        // data enable, low drives
  output logic                   addressStrobe_n,    // address strobe
  output logic                   readStrobe_n,       // read strobe
  output logic                   writeStrobe_n,      // write strobe
  output logic                   strobeOe_n,         // strobe enable, low drives
  input  wire logic              cycleExtend_n       // stretch strobe while low
);

  // ==========================================================================
  // input synchronisers
  logic       enInMeta_r;
  logic       enInSync_r;
  logic       extMeta_r;
  logic       extSync_r;
  logic [DATA_W-1:0] dinMeta_r;
  logic [DATA_W-1:0] dinSync_r;

  // grant from upstream
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enInMeta_r <= 1'b0;
      enInSync_r <= 1'b0;
    end else begin
      enInMeta_r <= chainEnableIn;
      enInSync_r <= enInMeta_r;
    end
  end

  // cycle extend idles high so that reset does not look like a hold
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      extMeta_r <= 1'b1;
      extSync_r <= 1'b1;
    end else begin
      extMeta_r <= cycleExtend_n;
      extSync_r <= extMeta_r;
    end
  end

  // data bus pins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dinMeta_r <= '0;
      dinSync_r <= '0;
    end else begin
      dinMeta_r <= dataBusIn;
      dinSync_r <= dinMeta_r;
    end
  end

  // ==========================================================================
  // sequencer
  cba_state_type     state_r;
  cba_state_type     state_nxt;
  cba_req_type       req_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [DATA_W-1:0] rdata_r;

  wire granted   = enInSync_r;
  wire cntDone   = (cnt_r == '0);
  wire holdOff   = !extSync_r;
  wire dataEnd   = cntDone && !holdOff;
  wire [DATA_W-1:0] statusByte = {req_r.isHalt, req_r.isDelay,
                                  req_r.isFetch, req_r.isRead,
                                  req_r.page};

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (coreReqValid) state_nxt = ST_REQ;
      ST_REQ:  if (granted) state_nxt = ST_ADS;
      ST_ADS:  if (cntDone) state_nxt = ST_DATA;
      ST_DATA: if (dataEnd) state_nxt = ST_DONE;
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // the cycle description is frozen for the whole cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_r <= '0;
    end else if (state_r == ST_IDLE && coreReqValid) begin
      req_r <= coreReq;
    end
  end

  // strobe timer: loaded at grant and at the end of the address strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (state_r == ST_REQ && granted) begin
      cnt_r <= ADS_CNT;
    end else if (state_r == ST_ADS && cntDone) begin
      cnt_r <= STROBE_CNT;
    end else if (!cntDone) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (state_r == ST_DATA && req_r.isRead) begin
      rdata_r <= dinSync_r;
    end
  end

  // ==========================================================================
  // next pin values, decoded from the next state
  wire              inAdsNxt   = (state_nxt == ST_ADS);
  wire              inData     = (state_nxt == ST_DATA);
  wire              ownNxt     = inAdsNxt || inData;
  wire              reqNxt     = (state_nxt == ST_REQ) || ownNxt;
  wire              passNxt    = reqNxt ? 1'b0 : enInSync_r;
  wire              rdStbNxt_n = !(inData && req_r.isRead);
  wire              wrStbNxt_n = !(inData && !req_r.isRead);
  wire              driveData  = inAdsNxt || !wrStbNxt_n;
  wire [DATA_W-1:0] dataNxt    = inAdsNxt ? statusByte : req_r.wdata;
  wire              finishing  = (state_r == ST_DATA) && dataEnd;
  wire [DATA_W-1:0] rdataNxt   = req_r.isRead ? dinSync_r : rdata_r;
  wire              readyNxt   = (state_nxt == ST_IDLE) && !coreReqValid;

  // ==========================================================================
  // arbitration pins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busRequestLine <= 1'b0;
      chainEnableOut <= 1'b0;
    end else begin
      busRequestLine <= reqNxt;
      chainEnableOut <= passNxt;
    end
  end

  // ==========================================================================
  // address pins, latched for the whole cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowAddressLines <= '0;
      lowAddressOe_n  <= 1'b1;
    end else begin
      lowAddressLines <= req_r.addr;
      lowAddressOe_n  <= !ownNxt;
    end
  end

  // ==========================================================================
  // strobe pins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addressStrobe_n <= 1'b1;
      readStrobe_n    <= 1'b1;
      writeStrobe_n   <= 1'b1;
      strobeOe_n      <= 1'b1;
    end else begin
      addressStrobe_n <= !inAdsNxt;
      readStrobe_n    <= rdStbNxt_n;
      writeStrobe_n   <= wrStbNxt_n;
      strobeOe_n      <= !ownNxt;
    end
  end

  // ==========================================================================
  // data bus pins: status byte during the address strobe, then write data
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dataBusOut  <= '0;
      dataBusOe_n <= 1'b1;
    end else begin
      dataBusOut  <= dataNxt;
      dataBusOe_n <= !driveData;
    end
  end

  // ==========================================================================
  // core side
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      coreReqReady <= 1'b0;
      coreDone     <= 1'b0;
    end else begin
      coreReqReady <= readyNxt;
      coreDone     <= finishing;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      coreRdata <= '0;
    end else if (finishing) begin
      coreRdata <= rdataNxt;
    end
  end

endmodule : cba_bus_access

/* verif/cba_bus_access_props.sv */
`timescale 1ns/1ps
module cba_bus_access_props
  import cba_pkg::*;
(
  input wire logic              sys_clk,         // clock
  input wire logic              rst_n,           // reset
  input wire logic              busRequestLine,  // request
  input wire logic              chainEnableOut,  // downstream grant
  input wire logic [ADDR_W-1:0] lowAddressLines, // address
  input wire logic              lowAddressOe_n,  // address enable
  input wire logic              dataBusOe_n,     // data enable
  input wire logic              addressStrobe_n, // address strobe
  input wire logic              readStrobe_n,    // read strobe
  input wire logic              writeStrobe_n,   // write strobe
  input wire logic              strobeOe_n,      // strobe enable
  input wire logic              cycleExtend_n    // extend
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // bus cycle checks
  a_strobe_excl: assert property (readStrobe_n || writeStrobe_n)
    else $error("read and write strobes both low");
  a_cycle_owned: assert property (!(readStrobe_n && writeStrobe_n && addressStrobe_n) |-> busRequestLine && !lowAddressOe_n)
    else $error("bus cycle without request");
  a_out_locked: assert property (busRequestLine |-> !chainEnableOut)
    else $error("downstream enabled while requesting");
  a_float_idle: assert property (!busRequestLine |-> strobeOe_n && lowAddressOe_n && dataBusOe_n)
    else $error("pins driven without bus");
  a_addr_held: assert property (!lowAddressOe_n && $past(!lowAddressOe_n) |-> $stable(lowAddressLines))
    else $error("address moved in cycle");
  a_ads_alone: assert property (!addressStrobe_n |-> readStrobe_n && writeStrobe_n && !dataBusOe_n)
    else $error("address strobe overlaps data strobe");
  a_ads_first: assert property ($fell(readStrobe_n) || $fell(writeStrobe_n) |-> $past(!addressStrobe_n) || $past(!addressStrobe_n, 2))
    else $error("data strobe without address strobe");
  a_write_drive: assert property (!writeStrobe_n |-> !dataBusOe_n)
    else $error("write data not driven");
  a_read_float: assert property (!readStrobe_n |-> dataBusOe_n)
    else $error("bus driven during read");
  a_extend_hold: assert property ((!(readStrobe_n && writeStrobe_n) && !cycleExtend_n)[*3] |=> !(readStrobe_n && writeStrobe_n))
    else $error("strobe ended during extend");
endmodule : cba_bus_access_props
bind cba_bus_access cba_bus_access_props u_props (.sys_clk, .rst_n, .busRequestLine,
  .chainEnableOut, .lowAddressLines, .lowAddressOe_n, .dataBusOe_n, .addressStrobe_n,
  .readStrobe_n, .writeStrobe_n, .strobeOe_n, .cycleExtend_n);

/* verif/cba_mem_model.sv */
`timescale 1ns/1ps
module cba_mem_model (
  input  wire logic        sys_clk,  // clock
  input  wire logic        rst_n,    // reset
  input  wire logic [11:0] addr,     // address lines
  input  wire logic [7:0]  dOut,     // device data drive
  input  wire logic        dOe_n,    // device data enable
  input  wire logic        ads_n,    // address strobe
  input  wire logic        rd_n,     // read strobe
  input  wire logic        wr_n,     // write strobe
  input  wire logic [7:0]  holdCyc,  // extension length
  output logic      [7:0]  dIn,      // resolved bus level
  output logic             ext_n,    // cycle extend
  output logic      [7:0]  status_r  // status byte latched
);
  logic [7:0] mem [0:15];
  logic [7:0] cnt_r;
  logic [7:0] junk_r;
  logic       act_r;
  assign ext_n = (cnt_r == 8'h00);
  assign dIn = !dOe_n ? dOut : (!rd_n && ext_n) ? mem[addr[3:0]] : junk_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00; junk_r <= 8'h5C; status_r <= 8'h00; act_r <= 1'b0;
    end else begin
      junk_r <= ~junk_r;
      act_r <= !rd_n || !wr_n;
      if (!ads_n && !dOe_n) status_r <= dOut;
      if (!wr_n && !dOe_n) mem[addr[3:0]] <= dOut;
      if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
      else if ((!rd_n || !wr_n) && !act_r) cnt_r <= holdCyc;
    end
  end
endmodule : cba_mem_model

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import cba_pkg::*;
  logic sys_clk = 0, rst_n = 0, coreReqValid = 0, chainEnableIn = 0;
  cba_req_type coreReq = '0;
  logic [7:0] holdCyc = 8'h00;
  logic coreReqReady, coreDone, busRequestLine, chainEnableOut, lowAddressOe_n, dataBusOe_n;
  logic addressStrobe_n, readStrobe_n, writeStrobe_n, strobeOe_n, cycleExtend_n;
  logic [7:0] coreRdata, dataBusIn, dataBusOut, status, rdat;
  logic [11:0] lowAddressLines;
  int mismatches = 0, cmp_count = 0, cyc = 0, len = 0, strobeLen = 0;
  cba_bus_access DUT (.sys_clk, .rst_n, .coreReq, .coreReqValid, .coreReqReady, .coreDone,
    .coreRdata, .chainEnableIn, .busRequestLine, .chainEnableOut, .lowAddressLines,
    .lowAddressOe_n, .dataBusIn, .dataBusOut, .dataBusOe_n, .addressStrobe_n, .readStrobe_n,
    .writeStrobe_n, .strobeOe_n, .cycleExtend_n);
  cba_mem_model u_mem (.sys_clk, .rst_n, .addr(lowAddressLines), .dOut(dataBusOut),
    .dOe_n(dataBusOe_n), .ads_n(addressStrobe_n), .rd_n(readStrobe_n), .wr_n(writeStrobe_n),
    .holdCyc, .dIn(dataBusIn), .ext_n(cycleExtend_n), .status_r(status));
  initial forever #12.5 sys_clk = ~sys_clk;
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  // ==========================================================
  // one bus cycle: request, delayed grant, completion
  task automatic run(input logic [11:0] a, input logic [3:0] pg, input logic rd, input logic f,
                     input logic [7:0] d, input int gnt, input logic [7:0] hold);
    int n;
    coreReq <= '{a, pg, rd, f, 1'b0, ~rd, d};
    coreReqValid <= 1'b1;
    holdCyc <= hold;
    n = 0;
    while (busRequestLine !== 1'b1 && n < 50) begin @(posedge sys_clk); n++; end
    repeat (gnt) @(posedge sys_clk);
    chk("strobe before grant", 1, addressStrobe_n);
    chk("chain out locked", 0, chainEnableOut);
    chainEnableIn <= 1'b1; // upstream grant once the bus is free
    n = 0;
    while (coreDone !== 1'b1 && n < 400) begin @(posedge sys_clk); n++; end
    rdat = coreRdata;
    chk("address", a, lowAddressLines);
    coreReqValid <= 1'b0;
    chainEnableIn <= 1'b0;
    @(posedge sys_clk);
    chk("request dropped", 0, busRequestLine);
    chk("status byte", {~rd, 1'b0, f, rd, pg}, status);
    if (rd) chk("read data", d, rdat);
    if (hold == 0) chk("strobe length", STROBE_CYC, strobeLen);
    else chk("strobe stretched", 1, strobeLen >= hold);
    @(posedge sys_clk);
  endtask : run
  always @(posedge sys_clk) begin
    cyc++;
    if (!readStrobe_n || !writeStrobe_n) len++;
    else if (len != 0) begin strobeLen = len; len = 0; end
    if (cyc == 5000) begin mismatches++; finish_test(); end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    chainEnableIn <= 1'b1; // enable raised first to check that it ripples through to chain enable out
    repeat (4) @(posedge sys_clk);
    chk("ripple high", 1, chainEnableOut);
    chainEnableIn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("ripple low", 0, chainEnableOut);
    chk("ready idle", 1, coreReqReady);
    run(12'h5A3, 4'hC, 1'b0, 1'b0, 8'hA5, 0, 8'h00);
    run(12'h5A3, 4'hC, 1'b1, 1'b1, 8'hA5, 5, 8'h3C);
    for (int i = 0; i < 4; i++) run(12'h8F8 + i, 4'(i), 1'b0, 1'b0, 8'h30 + 8'(i), 0, 8'h00);
    for (int i = 0; i < 4; i++) run(12'h8F8 + i, 4'(i), 1'b1, 1'b0, 8'h30 + 8'(i), 1, 8'h00);
    finish_test();
  end
endmodule : testbench
